// *** design/sbc_cfg.svh ***
`ifndef SBC_CFG_SVH
`define SBC_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define SBC_IDX_BUS 16'hff0c
`define SBC_IDX_SYS 16'hff12

// System configuration field positions
`define SBC_SYS_STK_HI 15
`define SBC_SYS_STK_LO 13
`define SBC_SYS_ROMSEG 12
`define SBC_SYS_SEGOFF 11
`define SBC_SYS_ROMON 10
`define SBC_SYS_BHEOFF 9
`define SBC_SYS_CLKON 8
`define SBC_SYS_WRITE_STROBE_CFG 7

// Default bus configuration field positions
`define SBC_BUS_RDY 12
`define SBC_BUS_ACT 10
`define SBC_BUS_ALE 9
`define SBC_BUS_TYP_HI 7
`define SBC_BUS_TYP_LO 6
`define SBC_BUS_MTTC 5
`define SBC_BUS_RWDC 4
`define SBC_BUS_CYCLE_WAIT_COUNT_HI 3
`define SBC_BUS_CYCLE_WAIT_COUNT_LO 0

// Reset values of the default bus parameters for external start
`define SBC_RST_CYCLE_WAIT_COUNT 4'h0
`define SBC_RST_RWDC 1'h0
`define SBC_RST_MTTC 1'h0
`define SBC_RST_ALE 1'h1
`define SBC_RST_ACT 1'h1
`define SBC_RST_RDY 1'h0

// Stack size codes
`define SBC_STK_256 3'h0
`define SBC_STK_128 3'h1
`define SBC_STK_64 3'h2
`define SBC_STK_32 3'h3
`define SBC_STK_512 3'h4
`define SBC_STK_NOWRAP 3'h7

// Stack window sizes in bytes and the byte above the window top
`define SBC_STK_BYTES_256 16'h0200
`define SBC_STK_BYTES_128 16'h0100
`define SBC_STK_BYTES_64 16'h0080
`define SBC_STK_BYTES_32 16'h0040
`define SBC_STK_BYTES_512 16'h0400
`define SBC_STK_TOP 16'hfc00

// Internal address map
`define SBC_SEG0 8'h00
`define SBC_INT_NIBBLE 4'hf
`define SBC_ROM_SEG_UPPER 7'h00

`endif

// *** design/sbc_pkg.sv ***
`default_nettype none

package sbc_pkg;

  typedef struct packed {
    logic [2:0] stack_size_sel;
    logic rom_segment_sel;
    logic segmentation_off;
    logic onchip_rom_on;
    logic byte_high_strobe_off;
    logic clock_out_on;
    logic write_strobe_cfg;
  } sbc_sys_cfg_t;

  typedef struct packed {
    logic ready_input_on;
    logic bus_active_bit;
    logic latch_pulse_lengthen;
    logic [1:0] bus_type;
    logic tristate_wait_ctl;
    logic rd_wr_delay_ctl;
    logic [3:0] cycle_wait_count;
  } sbc_bus_cfg_t;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic external;
    logic default_bus;
    logic region_select_n;
    logic ready_ok;
    logic [7:0] seg_addr;
  } sbc_acc_t;

  typedef struct packed {
    logic [2:0] ea_sync;
    logic [2:0][1:0] p0_sync;
    logic [2:0] rdy_sync;
    sbc_sys_cfg_t sys;
    sbc_bus_cfg_t bus;
    logic locked;
    logic ack;
    logic [31:0] rdata;
    sbc_acc_t acc;
    logic bus_enable;
  } sbc_state_t;

endpackage

`default_nettype wire

// *** design/sbc_top.sv ***
// Behaviour
// (R1) After end-of-init executes, all system config writes are silently ignored.
// (R2) Stack size codes: 256,128,64,32,512 words, two reserved, 111 no wrap.
// (R3) Codes 0..4 wrap stack accesses inside a window ending at FBFFh.
// (R4) No-wrap lets stack accesses use F600h..FDFFh unwrapped.
// (R5) Stack accesses always go to internal RAM, never external memory.
// (R6) Software never loads the stack pointer into SFR or reserved areas.
// (R7) ROM segment bit maps ROM to segment 0 or 1; resets to 0.
// (R8) Enabled ROM blocks external addresses in lower 32 KByte of its segment.
// (R9) Segmentation-off resets 0; gates segment output and pointer push/pop only.
// (R10) ROM enable is loaded from the external-access pin during reset.
// (R11) ROM enable 0 sends ROM-space accesses external; 1 keeps them on chip.
// (R12) Bit 9 set turns the byte-high strobe pin into general I/O.
// (R13) Bit 8 set makes the clock pin drive the system clock.
// (R14) Bit 7 set makes write and byte-high pins low and high write strobes.
// (R15) Software never changes ROM enable or segment while running from ROM.
// (R16) External-access pin high at reset clears default bus config to zero.
// (R17) Pin low at reset loads bus type from port pins plus slow defaults.
// (R18) Bus type: upper bit selects 16-bit width, lower bit multiplexing.
// (R19) Ready enable makes default-bus accesses honour the external ready input.
// (R20) Default bus config governs external accesses outside all programmed ranges.
// (R21) Enabled chip select 0 is low only for default-bus external accesses.
// (R22) External bus stays enabled while any bus active bit is set.
// (R23) Pins are sampled during reset; defaults hold from reset release.
// (R24) Reserved bits read zero, ignore writes; default bus bits 15,14 read zero.
//
// Local design decision: the Wishbone slave port.
`include "sbc_cfg.svh"
`default_nettype none

module sbc_top #(
  parameter int AW = 18
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Pins, sampled through synchronisers
  input wire logic external_access_pin_i,
  input wire logic [1:0] config_port_pins_i,
  input wire logic ext_ready_n_i,
  // Core side
  input wire logic end_init_instruction_i,
  input wire logic acc_valid_i,
  input wire logic [23:0] acc_addr_i,
  input wire logic acc_stack_i,
  input wire logic acc_in_range_i,
  input wire logic cs0_enable_i,
  input wire logic [3:0] other_bus_active_i,
  // Access decode results
  output logic acc_valid_o,
  output logic [23:0] acc_addr_o,
  output logic acc_external_o,
  output logic acc_default_bus_o,
  output logic default_region_select_n_o,
  output logic acc_ready_ok_o,
  output logic [7:0] segment_address_port_o,
  output logic bus_enable_o,
  // Configuration levels
  output sbc_pkg::sbc_sys_cfg_t sys_cfg_o,
  output sbc_pkg::sbc_bus_cfg_t bus_cfg_o,
  output logic code_segment_pointer_save_o,
  output logic byte_high_pin_io_o,
  output logic system_clock_out_o,
  output logic write_split_strobes_o,
  output logic cfg_locked_o
);

  sbc_pkg::sbc_state_t st;
  sbc_pkg::sbc_state_t next_st;

  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [15:0] idx);
    reg_hit = (a[AW-1:2] == idx[AW-3:0]) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] sel);
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction

  function automatic logic [15:0] sys_word(input sbc_pkg::sbc_sys_cfg_t s);
    sys_word = '0;
    sys_word[`SBC_SYS_STK_HI:`SBC_SYS_STK_LO] = s.stack_size_sel;
    sys_word[`SBC_SYS_ROMSEG] = s.rom_segment_sel;
    sys_word[`SBC_SYS_SEGOFF] = s.segmentation_off;
    sys_word[`SBC_SYS_ROMON] = s.onchip_rom_on;
    sys_word[`SBC_SYS_BHEOFF] = s.byte_high_strobe_off;
    sys_word[`SBC_SYS_CLKON] = s.clock_out_on;
    sys_word[`SBC_SYS_WRITE_STROBE_CFG] = s.write_strobe_cfg;
  endfunction

  function automatic logic [15:0] bus_word(input sbc_pkg::sbc_bus_cfg_t b);
    bus_word = '0; // Bits 15, 14 and reserved bits stay zero (see R24)
    bus_word[`SBC_BUS_RDY] = b.ready_input_on;
    bus_word[`SBC_BUS_ACT] = b.bus_active_bit;
    bus_word[`SBC_BUS_ALE] = b.latch_pulse_lengthen;
    bus_word[`SBC_BUS_TYP_HI:`SBC_BUS_TYP_LO] = b.bus_type;
    bus_word[`SBC_BUS_MTTC] = b.tristate_wait_ctl;
    bus_word[`SBC_BUS_RWDC] = b.rd_wr_delay_ctl;
    bus_word[`SBC_BUS_CYCLE_WAIT_COUNT_HI:`SBC_BUS_CYCLE_WAIT_COUNT_LO] = b.cycle_wait_count;
  endfunction

  // Window base is aligned to the size, so OR-ing the offset wraps it
  function automatic logic [15:0] stack_addr(input logic [2:0] code, input logic [15:0] sp);
    logic [15:0] sz;
    sz = '0;
    unique case (code)
      `SBC_STK_256: sz = `SBC_STK_BYTES_256;
      `SBC_STK_128: sz = `SBC_STK_BYTES_128;
      `SBC_STK_64: sz = `SBC_STK_BYTES_64;
      `SBC_STK_32: sz = `SBC_STK_BYTES_32;
      `SBC_STK_512: sz = `SBC_STK_BYTES_512; // see (R2)
      default: sz = '0;
    endcase
    // Reserved codes behave as no-wrap rather than picking a window
    if (sz == '0) begin
      stack_addr = sp; // see (R4)
    end else begin
      stack_addr = (`SBC_STK_TOP - sz) | (sp & (sz - 16'h0001)); // see (R3)
    end
  endfunction

  logic req;
  logic [1:0] p0_stable;
  logic ea_stable;
  logic ea_level;
  logic [1:0] p0_level;
  logic internal;
  logic rom_window;
  logic is_ext;
  logic [15:0] sys_new;
  logic [15:0] bus_new;

  always_comb begin
    next_st = st;
    req = cyc_i && stb_i && !st.ack;
    internal = 1'b0;
    rom_window = 1'b0;
    is_ext = 1'b0;
    sys_new = '0;
    bus_new = '0;
    next_st.ea_sync = {st.ea_sync[1:0], external_access_pin_i};
    next_st.p0_sync = {st.p0_sync[1:0], config_port_pins_i};
    next_st.rdy_sync = {st.rdy_sync[1:0], ext_ready_n_i};
    ea_stable = st.ea_sync[1] == st.ea_sync[2];
    p0_stable = ~(st.p0_sync[1] ^ st.p0_sync[2]);
    // A pin only counts once two later stages agree; else the old value holds
    ea_level = ea_stable ? st.ea_sync[2] : st.sys.onchip_rom_on;
    p0_level[0] = p0_stable[0] ? st.p0_sync[2][0] : st.bus.bus_type[0];
    p0_level[1] = p0_stable[1] ? st.p0_sync[2][1] : st.bus.bus_type[1];
    if (rst_i) begin
      // Pins keep being sampled for the whole reset; last agreed level stays (see R23)
      next_st.sys = '0; // see (R7) (R9)
      next_st.sys.onchip_rom_on = ea_level; // see (R10)
      next_st.bus = '0; // see (R16)
      if (!ea_level) begin
        next_st.bus.bus_type = p0_level; // see (R17) (R18)
        next_st.bus.cycle_wait_count = `SBC_RST_CYCLE_WAIT_COUNT;
        next_st.bus.rd_wr_delay_ctl = `SBC_RST_RWDC;
        next_st.bus.tristate_wait_ctl = `SBC_RST_MTTC;
        next_st.bus.latch_pulse_lengthen = `SBC_RST_ALE;
        next_st.bus.bus_active_bit = `SBC_RST_ACT;
        next_st.bus.ready_input_on = `SBC_RST_RDY;
      end
      next_st.locked = 1'b0;
      next_st.ack = 1'b0;
      next_st.rdata = '0;
      next_st.acc = '0;
      next_st.acc.region_select_n = 1'b1;
      next_st.bus_enable = 1'b0;
    end else begin
      next_st.ack = req;
      if (end_init_instruction_i) begin
        next_st.locked = 1'b1;
      end
      if (req) begin
        next_st.rdata = '0; // Unmapped addresses read zero and drop writes
        if (reg_hit(adr_i, `SBC_IDX_SYS)) begin
          next_st.rdata[15:0] = sys_word(st.sys);
          if (we_i && !st.locked) begin // see (R1)
            sys_new = merge16(sys_word(st.sys), dat_i, sel_i);
            next_st.sys.stack_size_sel = sys_new[`SBC_SYS_STK_HI:`SBC_SYS_STK_LO];
            next_st.sys.rom_segment_sel = sys_new[`SBC_SYS_ROMSEG];
            next_st.sys.segmentation_off = sys_new[`SBC_SYS_SEGOFF];
            next_st.sys.onchip_rom_on = sys_new[`SBC_SYS_ROMON];
            next_st.sys.byte_high_strobe_off = sys_new[`SBC_SYS_BHEOFF];
            next_st.sys.clock_out_on = sys_new[`SBC_SYS_CLKON];
            next_st.sys.write_strobe_cfg = sys_new[`SBC_SYS_WRITE_STROBE_CFG];
          end
        end else if (reg_hit(adr_i, `SBC_IDX_BUS)) begin
          next_st.rdata[15:0] = bus_word(st.bus);
          if (we_i) begin
            bus_new = merge16(bus_word(st.bus), dat_i, sel_i); // see (R24)
            next_st.bus.ready_input_on = bus_new[`SBC_BUS_RDY];
            next_st.bus.bus_active_bit = bus_new[`SBC_BUS_ACT];
            next_st.bus.latch_pulse_lengthen = bus_new[`SBC_BUS_ALE];
            next_st.bus.bus_type = bus_new[`SBC_BUS_TYP_HI:`SBC_BUS_TYP_LO];
            next_st.bus.tristate_wait_ctl = bus_new[`SBC_BUS_MTTC];
            next_st.bus.rd_wr_delay_ctl = bus_new[`SBC_BUS_RWDC];
            next_st.bus.cycle_wait_count = bus_new[`SBC_BUS_CYCLE_WAIT_COUNT_HI:`SBC_BUS_CYCLE_WAIT_COUNT_LO];
          end
        end
      end
      // Access classification, one cycle behind the request
      internal = (acc_addr_i[23:16] == `SBC_SEG0) &&
                 (acc_addr_i[15:12] == `SBC_INT_NIBBLE);
      rom_window = st.sys.onchip_rom_on && !acc_addr_i[15] &&
                   (acc_addr_i[23:16] == {`SBC_ROM_SEG_UPPER, st.sys.rom_segment_sel});
      is_ext = acc_valid_i && !acc_stack_i && !internal && !rom_window; // see (R8) (R11)
      next_st.acc.valid = acc_valid_i;
      if (acc_stack_i) begin
        // Stack never leaves segment 0 internal RAM
        next_st.acc.addr = {`SBC_SEG0, stack_addr(st.sys.stack_size_sel,
                                                  acc_addr_i[15:0])}; // see (R5)
      end else begin
        next_st.acc.addr = acc_addr_i;
      end
      next_st.acc.external = is_ext;
      next_st.acc.default_bus = is_ext && !acc_in_range_i; // see (R20)
      next_st.acc.region_select_n = !(cs0_enable_i && is_ext && !acc_in_range_i); // see (R21)
      next_st.acc.ready_ok = !(is_ext && !acc_in_range_i && st.bus.ready_input_on) ||
                             !st.rdy_sync[2]; // see (R19)
      next_st.acc.seg_addr = (is_ext && !st.sys.segmentation_off) ?
                             acc_addr_i[23:16] : '0; // see (R9)
      next_st.bus_enable = st.bus.bus_active_bit || (|other_bus_active_i); // see (R22)
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign acc_valid_o = st.acc.valid;
  assign acc_addr_o = st.acc.addr;
  assign acc_external_o = st.acc.external;
  assign acc_default_bus_o = st.acc.default_bus;
  assign default_region_select_n_o = st.acc.region_select_n;
  assign acc_ready_ok_o = st.acc.ready_ok;
  assign segment_address_port_o = st.acc.seg_addr;
  assign bus_enable_o = st.bus_enable;
  assign sys_cfg_o = st.sys;
  assign bus_cfg_o = st.bus;
  assign code_segment_pointer_save_o = !st.sys.segmentation_off; // see (R9)
  assign byte_high_pin_io_o = st.sys.byte_high_strobe_off; // see (R12)
  assign system_clock_out_o = st.sys.clock_out_on; // see (R13)
  assign write_split_strobes_o = st.sys.write_strobe_cfg; // see (R14)
  assign cfg_locked_o = st.locked;

endmodule

`default_nettype wire

// *** dv/sbc_ext_mem.sv ***
`default_nettype none
module sbc_ext_mem (
  // Bench control
  input wire logic clk_i,
  input wire logic slow_i,
  // Ready pin to the block
  output logic ready_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin has a pull-up, so a stalled part reads as not ready
  initial ready_n_o = 1'h1;
  always @(posedge clk_i) ready_n_o <= slow_i;
endmodule
`default_nettype wire

// *** dv/sbc_props.sv ***
`default_nettype none
module sbc_props (
  // Clock and stimulus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic end_init_instruction_i,
  input wire logic acc_valid_i,
  input wire logic acc_stack_i,
  input wire logic [23:0] acc_addr_i,
  // Block outputs
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  input wire logic [23:0] acc_addr_o,
  input wire logic acc_external_o,
  input wire logic acc_ready_ok_o,
  input wire logic [7:0] segment_address_port_o,
  input wire sbc_pkg::sbc_sys_cfg_t sys_cfg_o,
  input wire sbc_pkg::sbc_bus_cfg_t bus_cfg_o,
  input wire logic cfg_locked_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_lock; cfg_locked_o |=> cfg_locked_o && $stable(sys_cfg_o); endproperty
  a_lock: assert property (p_lock) else $error("locked config moved");
  property p_lock_set; end_init_instruction_i |=> cfg_locked_o; endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set");
  property p_stk_int; acc_valid_i && acc_stack_i |=> !acc_external_o; endproperty
  a_stk_int: assert property (p_stk_int) else $error("stack went external");
  property p_wrap;
    acc_valid_i && acc_stack_i && sys_cfg_o.stack_size_sel <= 3'h4
      |=> acc_addr_o >= 24'h00f800 && acc_addr_o <= 24'h00fbff;
  endproperty
  a_wrap: assert property (p_wrap) else $error("stack left window");
  property p_nowrap;
    acc_valid_i && acc_stack_i && sys_cfg_o.stack_size_sel == 3'h7
      |=> acc_addr_o == {8'h00, $past(acc_addr_i[15:0])};
  endproperty
  a_nowrap: assert property (p_nowrap) else $error("stack wrapped");
  property p_seg_off;
    acc_valid_i && sys_cfg_o.segmentation_off |=> segment_address_port_o == 8'h00;
  endproperty
  a_seg_off: assert property (p_seg_off) else $error("segment driven");
  property p_rdy_off; acc_valid_i && !bus_cfg_o.ready_input_on |=> acc_ready_ok_o; endproperty
  a_rdy_off: assert property (p_rdy_off) else $error("ready not ignored");
  property p_ack_hi; ack_o |-> dat_o[31:16] == 16'h0000; endproperty
  a_ack_hi: assert property (p_ack_hi) else $error("upper data set");
endmodule
bind sbc_top sbc_props u_props (.clk_i, .rst_i, .end_init_instruction_i, .acc_valid_i,
  .acc_stack_i, .acc_addr_i, .ack_o, .dat_o, .acc_addr_o, .acc_external_o, .acc_ready_ok_o,
  .segment_address_port_o, .sys_cfg_o, .bus_cfg_o, .cfg_locked_o);
`default_nettype wire

// *** dv/testbench.sv ***
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] sys_a = 18'h3fc48;
  localparam logic [17:0] bus_a = 18'h3fc30;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ea = 1'h0, endi = 1'h0, slow = 1'h0;
  logic av = 1'h0, ast = 1'h0, air = 1'h0, ce0 = 1'h0, lck_m = 1'h0;
  logic ack, avo, ext, dflt, csn, rok, ben, code_segment_pointer, bio, sco, wss, lck, rdyn;
  logic [1:0] pins = 2'h0;
  logic [3:0] oba = 4'h0;
  logic [7:0] seg;
  logic [15:0] r = 16'h749f, sm, bm;
  logic [17:0] adr = 18'h00000;
  logic [23:0] aa = 24'h000000, ao;
  logic [31:0] wd = 32'h00000000, rd, dat;
  sbc_pkg::sbc_sys_cfg_t sys;
  sbc_pkg::sbc_bus_cfg_t bus;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  sbc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h3), .dat_i(wd), .dat_o(dat), .ack_o(ack),
    .external_access_pin_i(ea), .config_port_pins_i(pins), .ext_ready_n_i(rdyn),
    .end_init_instruction_i(endi), .acc_valid_i(av), .acc_addr_i(aa), .acc_stack_i(ast),
    .acc_in_range_i(air), .cs0_enable_i(ce0), .other_bus_active_i(oba), .acc_valid_o(avo),
    .acc_addr_o(ao), .acc_external_o(ext), .acc_default_bus_o(dflt),
    .default_region_select_n_o(csn), .acc_ready_ok_o(rok), .segment_address_port_o(seg),
    .bus_enable_o(ben), .sys_cfg_o(sys), .bus_cfg_o(bus), .code_segment_pointer_save_o(code_segment_pointer),
    .byte_high_pin_io_o(bio), .system_clock_out_o(sco), .write_split_strobes_o(wss),
    .cfg_locked_o(lck));
  sbc_ext_mem mem (.clk_i(clk_i), .slow_i(slow), .ready_n_o(rdyn));
  initial forever #5 clk_i = ~clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic wb(input logic w, input logic [17:0] a, input logic [15:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wd <= {16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'h1);
    rd = dat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask
  // Straps held through the whole reset so the pin synchronisers settle
  task automatic do_reset(input logic e, input logic [1:0] p);
    rst_i <= 1'h1;
    ea <= e;
    pins <= p;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    sm = e ? 16'h0400 : 16'h0000;
    bm = e ? 16'h0000 : {8'h06, p, 6'h00};
    lck_m = 1'h0;
  endtask
  task automatic regs();
    wb(1'h0, sys_a, 16'h0000);
    chk(rd, sm);
    wb(1'h0, bus_a, 16'h0000);
    chk(rd, bm);
    chk(sys, sm[15:7]);
    chk(bus, {bm[12], bm[10:9], bm[7:0]});
    chk({code_segment_pointer, bio, sco, wss, lck}, {~sm[11], sm[9:7], lck_m});
  endtask
  task automatic dec();
    logic [23:0] a;
    logic [15:0] s, b;
    logic x;
    r = lfsr(r);
    a = {7'h00, r[15], lfsr(r)};
    // Stack pointer kept inside internal RAM words, never SFR or reserved space
    if (r[0]) a[15:0] = 16'hf600 + (a[15:0] & 16'h07fe);
    av <= 1'h1;
    aa <= a;
    ast <= r[0];
    air <= r[1];
    ce0 <= r[2];
    oba <= r[6:3] & {4{r[7]}};
    repeat (3) @(posedge clk_i);
    x = a[23:12] != 12'h00f && !(sm[10] && a[23:15] == {7'h00, sm[12], 1'h0}) && !r[0];
    b = sm[15:13] == 3'h4 ? 16'h0400 : 16'h0200 >> sm[15:13];
    s = sm[15:13] > 3'h4 ? a[15:0] : ((16'hfc00 - b) | (a[15:0] & (b - 16'h0001)));
    chk(avo, 1'h1);
    chk(ao, r[0] ? {8'h00, s} : a);
    chk(ext, x);
    chk(dflt, x && !r[1]);
    chk(csn, !(x && !r[1] && r[2]));
    chk(seg, (x && !sm[11]) ? a[23:16] : 8'h00);
    chk(rok, !(x && !r[1] && bm[12] && slow));
    chk(ben, bm[10] || oba != 4'h0);
  endtask
  initial begin
    for (int i = 0; i < 5; i++) begin
      do_reset(i == 4, 2'(i));
      regs();
    end
    wb(1'h0, 18'h3fc34, 16'h0000);
    chk(rd, 32'h0);
    for (int i = 0; i < 9; i++) begin
      if (i == 8) begin
        endi <= 1'h1;
        @(posedge clk_i);
        endi <= 1'h0;
        lck_m = 1'h1;
      end
      r = lfsr(r);
      slow <= r[1];
      // No code runs from on-chip ROM here, so remapping it is safe
      wb(1'h1, sys_a, {3'(i), r[12:0]});
      if (!lck_m) sm = {3'(i), r[12:7], 7'h00};
      r = lfsr(r);
      wb(1'h1, bus_a, r);
      bm = r & 16'h16ff;
      regs();
      dec();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
